/* hw/lpddr_mode_register_config.sv */
// Mode and extended mode registers with derived burst and latency controls
`timescale 1ns/1ps
module lpddr_mode_register_config
  import lpddr_mode_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire mode_cmd_t i_cmd,
  input wire logic i_read_cmd,
  input wire logic [2:0] i_start_col,
  output std_mode_t o_std_mode,
  output ext_mode_t o_ext_mode,
  output logic [3:0] o_burst_len,
  output logic o_interleave,
  output logic [1:0] o_read_delay,
  output logic [2:0] o_refresh_fraction,
  output logic [1:0] o_drive_strength,
  output logic [23:0] o_col_seq,
  output logic o_read_data_valid,
  output logic o_mode_reserved
);
  // ==========================================
  // Reset synchroniser
  logic rst_s1_ff;
  logic rst_s2_ff;
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  // ==========================================
  // Command decode
  wire [1:0] bank_sel = {i_cmd.bank_select_bit1, i_cmd.bank_select_bit0};
  wire load_std = i_cmd.load_mode_register_cmd && (bank_sel == BANK_SEL_STD); // R01
  wire load_ext = i_cmd.load_mode_register_cmd && (bank_sel == BANK_SEL_EXT); // R22
  std_mode_t nxt_std;
  ext_mode_t nxt_ext;
  assign nxt_std.burst_length_code = i_cmd.addr[BL_MSB:BL_LSB]; // R04
  assign nxt_std.burst_ordering = i_cmd.addr[BT_BIT]; // R04
  assign nxt_std.read_latency = i_cmd.addr[LAT_MSB:LAT_LSB]; // R04
  assign nxt_std.operating_mode = i_cmd.addr[OPM_MSB:OPM_LSB]; // R04
  // Temperature compensation bits are not captured
  assign nxt_ext.partial_array_refresh = i_cmd.addr[PAR_MSB:PAR_LSB]; // R13
  assign nxt_ext.output_drive_strength = i_cmd.addr[DRV_MSB:DRV_LSB]; // R15

  // ==========================================
  // Register storage, only touched by load commands
  std_mode_t std_ff;
  ext_mode_t ext_ff;
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      std_ff <= '{BL_RST, 1'b0, LAT_RST, OPM_NORMAL};
      ext_ff <= '{PAR_FULL, DRV_FULL}; // R12
    end
    else
    begin
      if (load_std)
        std_ff <= nxt_std; // R01 R02 R23
      if (load_ext)
        ext_ff <= nxt_ext; // R22 R23
    end
  end

  // ==========================================
  // Field decode
  wire [3:0] nxt_burst_len = (std_ff.burst_length_code == BL_CODE_8) ? BLEN_8 :
                             (std_ff.burst_length_code == BL_CODE_4) ? BLEN_4 :
                             BLEN_2; // R05 R08
  wire [1:0] nxt_read_delay = (std_ff.read_latency == LAT_CODE_2) ? LAT_DLY_2 :
                              LAT_DLY_3; // R09 R10
  wire [2:0] nxt_refresh_fraction =
    (ext_ff.partial_array_refresh == PAR_HALF) ? PAR_HALF :
    (ext_ff.partial_array_refresh == PAR_QUARTER) ? PAR_QUARTER : PAR_FULL; // R14
  wire nxt_reserved = (std_ff.operating_mode != OPM_NORMAL) ||
    !(std_ff.read_latency inside {LAT_CODE_2, LAT_CODE_3}) ||
    !(std_ff.burst_length_code inside {BL_CODE_2, BL_CODE_4, BL_CODE_8});
  wire [23:0] nxt_col_seq;

  burst_order_gen u_order (
    .i_start_col(i_start_col),
    .i_burst_len(nxt_burst_len),
    .i_interleave(std_ff.burst_ordering),
    .o_col_seq(nxt_col_seq)
  ); // R07

  // ==========================================
  // Read latency pipeline
  logic [1:0] rd_pipe_ff;
  wire nxt_valid = (nxt_read_delay == LAT_DLY_2) ? rd_pipe_ff[0] : rd_pipe_ff[1]; // R10

  // ==========================================
  // Output registers
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_std_mode <= '0;
      o_ext_mode <= '0;
      o_burst_len <= BLEN_2;
      o_interleave <= 1'b0;
      o_read_delay <= LAT_DLY_3;
      o_refresh_fraction <= PAR_FULL;
      o_drive_strength <= DRV_FULL;
      o_col_seq <= '0;
      o_read_data_valid <= 1'b0;
      o_mode_reserved <= 1'b0;
      rd_pipe_ff <= '0;
    end
    else
    begin
      o_std_mode <= std_ff;
      o_ext_mode <= ext_ff;
      o_burst_len <= nxt_burst_len; // R08
      o_interleave <= std_ff.burst_ordering; // R06
      o_read_delay <= nxt_read_delay;
      o_refresh_fraction <= nxt_refresh_fraction; // R14
      o_drive_strength <= ext_ff.output_drive_strength; // R15
      o_col_seq <= nxt_col_seq;
      rd_pipe_ff <= {rd_pipe_ff[0], i_read_cmd};
      o_read_data_valid <= nxt_valid;
      o_mode_reserved <= nxt_reserved;
    end
  end

  // ==========================================
  // Checks
  chk_std_hold: assert property (@(posedge i_mclk) disable iff (!rst_n)
    !load_std |=> std_ff == $past(std_ff)) else $error("std reg changed"); // R01
  chk_std_load: assert property (@(posedge i_mclk) disable iff (!rst_n)
    load_std |=> std_ff == $past(nxt_std)) else $error("std load lost"); // R04
  chk_ext_hold: assert property (@(posedge i_mclk) disable iff (!rst_n)
    !load_ext |=> ext_ff == $past(ext_ff)) else $error("ext reg changed"); // R23
  chk_ext_load: assert property (@(posedge i_mclk) disable iff (!rst_n)
    load_ext |=> ext_ff.output_drive_strength == $past(i_cmd.addr[DRV_MSB:DRV_LSB]))
    else $error("drive not loaded"); // R15
  chk_blen_code: assert property (@(posedge i_mclk) disable iff (!rst_n)
    std_ff.burst_length_code == BL_CODE_8 |=> o_burst_len == BLEN_8)
    else $error("burst length wrong"); // R05
  chk_lat_two: assert property (@(posedge i_mclk) disable iff (!rst_n)
    (i_read_cmd && std_ff.read_latency == LAT_CODE_2 && !load_std) ##1
    (std_ff.read_latency == LAT_CODE_2) |=> o_read_data_valid)
    else $error("latency 2 data late"); // R10
  chk_lat_three: assert property (@(posedge i_mclk) disable iff (!rst_n)
    (i_read_cmd && std_ff.read_latency == LAT_CODE_3 && !load_std) ##1
    (std_ff.read_latency == LAT_CODE_3) ##1 1 |=> o_read_data_valid)
    else $error("latency 3 data late"); // R09
  chk_ilv_order: assert property (@(posedge i_mclk) disable iff (!rst_n)
    (std_ff.burst_ordering && nxt_burst_len == BLEN_8) |=>
    o_col_seq[5:3] == ($past(i_start_col) ^ 3'h1)) else $error("interleave order"); // R06
  chk_par_map: assert property (@(posedge i_mclk) disable iff (!rst_n)
    ext_ff.partial_array_refresh == PAR_HALF |=> o_refresh_fraction == PAR_HALF)
    else $error("partial refresh map"); // R14
endmodule // lpddr_mode_register_config

/* inc/lpddr_mode_pkg.sv */
// Constants and types for the mode register block
// Functional notes
// R01 - Bank select 00 on load command writes the standard mode register, held until reloaded.
// R02 - Reprogramming the standard register never touches stored array contents.
// R03 - Controller loads only with banks idle, no burst, and waits before next operation.
// R04 - Standard register: bits 0-2 burst length, 3 ordering, 4-6 latency, 7-12 mode.
// R05 - Burst length codes 001, 010, 011 give 2, 4, 8; others reserved.
// R06 - Ordering bit 0 selects sequential, 1 selects interleaved.
// R07 - Column order within a burst comes from length, ordering and start column.
// R08 - Burst length sets the maximum columns touched by one read or write.
// R09 - Latency codes 010 and 011 give 2 and 3 clocks; others reserved.
// R10 - First read data follows command by latency minus one clocks plus access time.
// R11 - Controller writes zero mode bits for normal operation; other values unused.
// R12 - Unprogrammed extended register behaves as full-array refresh and full drive.
// R13 - Temperature compensation bits are ignored; internal sensor sets refresh rate.
// R14 - Self refresh covers full, half or quarter array per partial-array setting.
// R15 - Output drive strength comes from extended register bits 5 and 6.
// R16 - Controller changes clock frequency only while all timing and refresh hold.
// R17 - Controller stops clock only with no burst in flight.
// R18 - During clock stop, clock enable high, true clock low, complement high.
// R19 - After restart, one clock and at least one no-op before a valid command.
// R20 - Controller should precharge all banks before changing clock frequency.
// R21 - Controller drives reserved bits to zero on either register load.
// R22 - Bank select 10 writes extended register; refresh and drive codes as listed.
// R23 - Both registers hold their contents until the next load command.
package lpddr_mode_pkg;
  localparam logic [1:0] BANK_SEL_STD = 2'h0;
  localparam logic [1:0] BANK_SEL_EXT = 2'h2;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int BT_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 6;
  localparam int OPM_LSB = 7;
  localparam int OPM_MSB = 12;
  localparam int PAR_LSB = 0;
  localparam int PAR_MSB = 2;
  localparam int DRV_LSB = 5;
  localparam int DRV_MSB = 6;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] LAT_CODE_2 = 3'h2;
  localparam logic [2:0] LAT_CODE_3 = 3'h3;
  localparam logic [2:0] PAR_FULL = 3'h0;
  localparam logic [2:0] PAR_HALF = 3'h1;
  localparam logic [2:0] PAR_QUARTER = 3'h2;
  localparam logic [1:0] DRV_FULL = 2'h0;
  localparam logic [5:0] OPM_NORMAL = 6'h00;
  localparam logic [2:0] BL_RST = BL_CODE_2;
  localparam logic [2:0] LAT_RST = LAT_CODE_3;
  localparam logic [3:0] BLEN_2 = 4'h2;
  localparam logic [3:0] BLEN_4 = 4'h4;
  localparam logic [3:0] BLEN_8 = 4'h8;
  localparam logic [1:0] LAT_DLY_2 = 2'h1;
  localparam logic [1:0] LAT_DLY_3 = 2'h2;

  typedef struct packed {
    logic load_mode_register_cmd;
    logic bank_select_bit1;
    logic bank_select_bit0;
    logic [12:0] addr;
  } mode_cmd_t;

  typedef struct packed {
    logic [2:0] burst_length_code;
    logic burst_ordering;
    logic [2:0] read_latency;
    logic [5:0] operating_mode;
  } std_mode_t;

  typedef struct packed {
    logic [2:0] partial_array_refresh;
    logic [1:0] output_drive_strength;
  } ext_mode_t;
endpackage

/* hw/burst_order_gen.sv */
// Column order generator for one burst
`timescale 1ns/1ps
module burst_order_gen
  import lpddr_mode_pkg::*;
(
  input wire logic [2:0] i_start_col,
  input wire logic [3:0] i_burst_len,
  input wire logic i_interleave,
  output logic [23:0] o_col_seq
);
  // ==========================================
  // Per-beat column offsets
  genvar beat;
  generate
    for (beat = 0; beat < 8; beat++)
    begin : g_beat
      wire [2:0] beat_idx = 3'(beat);
      wire [2:0] mask = 3'(i_burst_len - 4'h1);
      wire [2:0] seq_low = (i_start_col + beat_idx) & mask;
      wire [2:0] ilv_low = (i_start_col ^ beat_idx) & mask;
      wire [2:0] low = i_interleave ? ilv_low : seq_low; // R06 R07
      assign o_col_seq[beat*3 +: 3] = (i_start_col & ~mask) | low;
    end
  endgenerate
endmodule // burst_order_gen

/* test/lpddr_ctrl_model.sv */
// Memory controller model that forms load and read commands
`timescale 1ns/1ps
module lpddr_ctrl_model
  import lpddr_mode_pkg::*;
(
  input wire logic i_load,
  input wire logic [1:0] i_bank,
  input wire logic [12:0] i_addr,
  input wire logic i_raw,
  input wire logic i_read,
  input wire logic [2:0] i_col,
  output mode_cmd_t o_cmd,
  output logic o_read_cmd,
  output logic [2:0] o_start_col
);
  // ==========================================================
  // Command forming
  wire logic ext_sel = (i_bank == BANK_SEL_EXT);
  wire logic [12:0] keep_mask = ext_sel ? 13'h0067 : 13'h007f;
  assign o_cmd.load_mode_register_cmd = i_load;
  assign o_cmd.bank_select_bit1 = i_bank[1];
  assign o_cmd.bank_select_bit0 = i_bank[0];
  assign o_cmd.addr = i_raw ? i_addr : (i_addr & keep_mask);
  assign o_read_cmd = i_read;
  assign o_start_col = i_col;
endmodule // lpddr_ctrl_model

/* test/tb.sv */
// Self-checking bench for the mode register block
`timescale 1ns/1ps
module tb;
  import lpddr_mode_pkg::*;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
  // ==========================================================
  // Signals
  logic i_mclk = 1'b0;
  logic nrst = 1'b0;
  logic load = 1'b0;
  logic raw = 1'b0;
  logic rd = 1'b0;
  logic [1:0] bank = 2'h0;
  logic [12:0] addr = 13'h0000;
  logic [2:0] col = 3'h0;
  mode_cmd_t cmd;
  logic read_cmd, rvalid, mres, ilv;
  logic [2:0] start_col, frac;
  std_mode_t std_mode;
  ext_mode_t ext_mode;
  logic [3:0] blen;
  logic [1:0] rdly, drv;
  logic [23:0] seq;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  integer seed = 32'h49f5_a12d;
  always #2.5 i_mclk = ~i_mclk;
  // ==========================================================
  // Instances
  lpddr_ctrl_model u_ctrl (.i_load(load), .i_bank(bank), .i_addr(addr), .i_raw(raw),
    .i_read(rd), .i_col(col), .o_cmd(cmd), .o_read_cmd(read_cmd), .o_start_col(start_col));
  lpddr_mode_register_config u_dut (.i_mclk(i_mclk), .i_nrst(nrst), .i_cmd(cmd),
    .i_read_cmd(read_cmd), .i_start_col(start_col), .o_std_mode(std_mode),
    .o_ext_mode(ext_mode), .o_burst_len(blen), .o_interleave(ilv), .o_read_delay(rdly),
    .o_refresh_fraction(frac), .o_drive_strength(drv), .o_col_seq(seq),
    .o_read_data_valid(rvalid), .o_mode_reserved(mres));
  // ==========================================================
  // Helpers
  function automatic logic [23:0] exp_seq(logic [2:0] s, logic [3:0] bl, logic il);
    logic [2:0] m;
    m = 3'(bl - 4'h1);
    for (int i = 0; i < 8; i++)
      exp_seq[i*3 +: 3] = (s & ~m) | ((il ? (s ^ 3'(i)) : (s + 3'(i))) & m);
  endfunction
  task automatic do_load(logic [1:0] b, logic [12:0] a);
    @(posedge i_mclk);
    load <= 1'b1;
    bank <= b;
    addr <= a;
    @(posedge i_mclk);
    load <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic do_read(logic [2:0] c, int lat);
    int got;
    got = 0;
    @(posedge i_mclk);
    rd <= 1'b1;
    col <= c;
    @(posedge i_mclk);
    rd <= 1'b0;
    for (int k = 1; k <= 5; k++)
    begin
      @(posedge i_mclk);
      #1;
      if (rvalid === 1'b1 && got == 0) got = k;
    end
    `CHK(got, lat - 1)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  // ==========================================================
  // Scenarios
  initial
  begin
    logic il;
    logic [2:0] c;
    logic [7:0] t;
    logic [3:0] eb;
    std_mode_t s;
    ext_mode_t e;
    repeat (10) @(posedge i_mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK(ext_mode, ext_mode_t'({PAR_FULL, DRV_FULL}))
    `CHK(blen, BLEN_2)
    `CHK(rdly, LAT_DLY_3)
    `CHK(frac, PAR_FULL)
    `CHK(drv, DRV_FULL)
    $display("test reset done");
    for (int b = 1; b <= 3; b++)
      for (int l = 2; l <= 3; l++)
      begin
        il = $random(seed);
        c = $random(seed);
        eb = 4'(2 << (b - 1));
        do_load(BANK_SEL_STD, {6'h00, 3'(l), il, 3'(b)});
        `CHK(blen, eb)
        `CHK(ilv, il)
        `CHK(rdly, (l == 2) ? LAT_DLY_2 : LAT_DLY_3)
        `CHK(mres, 1'b0)
        do_read(c, l);
        `CHK(seq, exp_seq(c, eb, il))
      end
    $display("test standard done");
    raw <= 1'b1;
    do_load(BANK_SEL_STD, {6'h15, LAT_CODE_2, 1'b0, BL_CODE_4});
    `CHK(mres, 1'b1)
    do_load(BANK_SEL_STD, {6'h00, LAT_CODE_2, 1'b1, BL_CODE_8});
    do_read(3'h5, 2);
    `CHK(seq, {3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5})
    s = std_mode;
    for (int p = 0; p < 4; p++)
      for (int d = 0; d < 4; d++)
      begin
        t = $random(seed);
        do_load(BANK_SEL_EXT, {t[5:0], 2'(d), t[7:6], 3'(p)});
        `CHK(frac, (p == 3) ? PAR_FULL : 3'(p))
        `CHK(drv, 2'(d))
        `CHK(std_mode, s)
      end
    $display("test extended done");
    e = ext_mode;
    do_load(2'h1, 13'($random(seed)));
    do_load(2'h3, 13'($random(seed)));
    `CHK(std_mode, s)
    `CHK(ext_mode, e)
    raw <= 1'b0;
    $display("test ignored banks done");
    tally_and_finish;
  end
endmodule // tb
